// file: core/frsd_pkg.sv
/*
 * Shared constants and types of the FP round and select decoder.
 * Assumes 32-bit instruction words with the first halfword in bits 31:16.
 */
`default_nettype none

package frsd_pkg;
    // Opcode match masks and values, the register index fields left open.
    localparam logic [31:0] RINT_MASK = 32'hffbf0e50;
    localparam logic [31:0] RINT_VALUE = 32'heeb60a40;
    localparam logic [31:0] EXACT_MASK = 32'hffbf0ed0;
    localparam logic [31:0] EXACT_VALUE = 32'heeb70a40;
    localparam logic [31:0] SEL_MASK = 32'hff800e50;
    localparam logic [31:0] SEL_VALUE = 32'hfe000a00;

    // Field positions inside the instruction word.
    localparam int DEST_EXT_BIT = 22;
    localparam int COND_HI = 21;
    localparam int COND_LO = 20;
    localparam int SRC1_HI = 19;
    localparam int SRC1_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 12;
    localparam int PRECISION_BIT = 8;
    localparam int OVERRIDE_BIT = 7;
    localparam int SRC1_EXT_BIT = 7;
    localparam int SRC2_EXT_BIT = 5;
    localparam int SRC2_HI = 3;
    localparam int SRC2_LO = 0;

    // Rounding mode field of the FP status and control register.
    localparam int RMODE_HI = 23;
    localparam int RMODE_LO = 22;

    // Flag positions in the program flags word (N, Z, C, V).
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 0;

    localparam int SP_EXP_W = 8;
    localparam int SP_MAN_W = 23;
    localparam int DP_EXP_W = 11;
    localparam int DP_MAN_W = 52;
    localparam int SP_W = 32;
    localparam int DP_W = 64;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'h0,
        RM_PLUS = 2'h1,
        RM_MINUS = 2'h2,
        RM_ZERO = 2'h3
    } frsd_rmode_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_RINT_CUR = 3'h1,
        OP_RINT_EXACT = 3'h2,
        OP_RINT_ZERO = 3'h3,
        OP_SELECT = 3'h4
    } frsd_op_t;
endpackage

`default_nettype wire

// file: core/frsd_round_if.sv
/*
 * Carrier between the decoder and one round-to-integral unit.
 * Assumes the unit is purely combinational.
 */
`default_nettype none

interface frsd_round_if #(parameter int W = 32);
    logic [W-1:0] operand;
    logic [W-1:0] result;
    frsd_pkg::frsd_rmode_t rmode;
    logic inexact;
    logic invalid;
    modport unit(input operand, rmode, output result, inexact, invalid);
    modport user(output operand, rmode, input result, inexact, invalid);
endinterface

`default_nettype wire

// file: core/frsd_round_int.sv
/*
 * Combinational round-to-integral for one IEEE binary format.
 * Assumes the caller qualifies inexact and invalid by the operation.
 */
`default_nettype none

module frsd_round_int #(
    parameter int EXP_W = 8,
    parameter int MAN_W = 23
) (
    frsd_round_if.unit port
);
    localparam int W = 1 + EXP_W + MAN_W;
    localparam logic [EXP_W-1:0] BIAS = {1'b0, {(EXP_W-1){1'b1}}};
    localparam logic [EXP_W-1:0] BIAS_M1 = BIAS - EXP_W'(1);
    localparam logic [EXP_W-1:0] EXP_ALL = '1;
    localparam logic [EXP_W:0] INT_EXP = (EXP_W+1)'(BIAS) + (EXP_W+1)'(MAN_W);

    logic sign;
    logic lsb;
    logic up;
    logic [EXP_W-1:0] expo;
    logic [MAN_W-1:0] frac;
    logic [MAN_W:0] mant;
    logic [MAN_W:0] mask;
    logic [MAN_W:0] half;
    logic [MAN_W:0] rem;
    logic [MAN_W:0] trunc;
    logic [MAN_W+1:0] sum;
    logic [EXP_W:0] fracBits;

    always_comb begin
        sign = port.operand[W-1];
        expo = port.operand[W-2:MAN_W];
        frac = port.operand[MAN_W-1:0];
        mant = {1'b1, frac};
        fracBits = INT_EXP - {1'b0, expo};
        mask = ~({(MAN_W+1){1'b1}} << fracBits);
        half = (MAN_W+1)'(1) << (fracBits - (EXP_W+1)'(1));
        rem = mant & mask;
        trunc = mant & ~mask;
        lsb = |(trunc & (half << 1));
        case (port.rmode)
            frsd_pkg::RM_NEAREST: up = (rem > half) || (rem == half && lsb);
            frsd_pkg::RM_PLUS: up = !sign && (rem != '0);
            frsd_pkg::RM_MINUS: up = sign && (rem != '0);
            default: up = 1'b0;
        endcase
        sum = {1'b0, trunc} + (up ? {1'b0, half} << 1 : '0);
        port.result = port.operand;
        port.inexact = 1'b0;
        port.invalid = 1'b0;
        // Zeros, infinities and integral values pass unchanged in size.
        if (expo == EXP_ALL) begin
            if (frac != '0) begin
                // Quieten the NaN; a signalling one reports invalid.
                port.result[MAN_W-1] = 1'b1;
                port.invalid = !frac[MAN_W-1];
            end
        end else if ({1'b0, expo} >= INT_EXP) begin
            port.result = port.operand;
        end else if (expo < BIAS) begin
            if (expo != '0 || frac != '0) begin
                port.inexact = 1'b1;
                port.result = {sign, {(W-1){1'b0}}};
                if ((port.rmode == frsd_pkg::RM_NEAREST && expo == BIAS_M1
                        && frac != '0)
                        || (port.rmode == frsd_pkg::RM_PLUS && !sign)
                        || (port.rmode == frsd_pkg::RM_MINUS && sign)) begin
                    port.result = {sign, BIAS, {MAN_W{1'b0}}};
                end
            end
        end else begin
            port.inexact = (rem != '0);
            if (sum[MAN_W+1]) begin
                port.result = {sign, expo + EXP_W'(1), {MAN_W{1'b0}}};
            end else begin
                port.result = {sign, expo, sum[MAN_W-1:0]};
            end
        end
    end
endmodule

`default_nettype wire

// file: core/fp_round_select_decode.sv
/*
 * Decode and execute of the FP round-to-integral and conditional select
 * group. Stage one decodes and registers indices and fault flags; the
 * register file answers the indices in the next cycle on src1Data and
 * src2Data, and stage two registers the result.
 * Assumes all inputs come from logic on clk.
 */
`default_nettype none

module fp_round_select_decode (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instrValid,
    input wire logic [31:0] instr,
    input wire logic instrCondPassed,
    input wire logic inItBlock,
    input wire logic fpExtPresent,
    input wire logic spOnlyImpl,
    input wire logic fpAccessEnabled,
    input wire logic [31:0] fpStatusControl,
    input wire logic [3:0] programFlags,
    input wire logic [63:0] src1Data,
    input wire logic [63:0] src2Data,
    output logic decodeValid_q,
    output frsd_pkg::frsd_op_t opKind_q,
    output logic double_q,
    output logic [4:0] destIndex_q,
    output logic [4:0] src1Index_q,
    output logic [4:0] src2Index_q,
    output logic undefined_q,
    output logic unpredictable_q,
    output logic fpDisabled_q,
    output logic resultValid_q,
    output frsd_pkg::frsd_op_t resultKind_q,
    output logic resultDouble_q,
    output logic [4:0] resultDest_q,
    output logic [63:0] resultData_q,
    output logic inexact_q,
    output logic invalid_q
);
    function automatic logic [4:0] formIndex(input logic dp,
            input logic [3:0] field, input logic extra);
        formIndex = dp ? {extra, field} : {field, extra};
    endfunction

    logic isRint;
    logic isExact;
    logic isSel;
    logic inGroup;
    logic dp;
    logic passes;
    logic execA_q;
    logic execA_d;
    logic condHolds_q;
    logic condHolds_d;
    logic [3:0] cond;
    frsd_pkg::frsd_rmode_t rmode_q;
    frsd_pkg::frsd_rmode_t rmode_d;
    frsd_pkg::frsd_op_t opKind_d;
    logic decodeValid_d;
    logic double_d;
    logic [4:0] destIndex_d;
    logic [4:0] src1Index_d;
    logic [4:0] src2Index_d;
    logic undefined_d;
    logic unpredictable_d;
    logic fpDisabled_d;

    ////////////////////////////////////////////////////////////////////////
    // Decode stage.

    always_comb begin
        isRint = (instr & frsd_pkg::RINT_MASK) == frsd_pkg::RINT_VALUE;
        isExact = (instr & frsd_pkg::EXACT_MASK) == frsd_pkg::EXACT_VALUE;
        isSel = (instr & frsd_pkg::SEL_MASK) == frsd_pkg::SEL_VALUE;
        inGroup = instrValid && (isRint || isExact || isSel);
        dp = instr[frsd_pkg::PRECISION_BIT];
        // Select is unconditional; the round forms obey the if-then state.
        passes = isSel || instrCondPassed;
        decodeValid_d = inGroup;
        double_d = dp;
        undefined_d = inGroup && (!fpExtPresent || (dp && spOnlyImpl));
        unpredictable_d = inGroup && isSel && inItBlock;
        // An unpredictable select still executes normally here.
        fpDisabled_d = inGroup && !undefined_d && passes && !fpAccessEnabled;
        execA_d = inGroup && !undefined_d && passes && fpAccessEnabled;
        if (isExact) begin
            opKind_d = frsd_pkg::OP_RINT_EXACT;
        end else if (isRint) begin
            opKind_d = instr[frsd_pkg::OVERRIDE_BIT] ? frsd_pkg::OP_RINT_ZERO
                                                     : frsd_pkg::OP_RINT_CUR;
        end else if (isSel) begin
            opKind_d = frsd_pkg::OP_SELECT;
        end else begin
            opKind_d = frsd_pkg::OP_NONE;
        end
        // Exact and current-mode forms both use the status register mode.
        rmode_d = (isRint && instr[frsd_pkg::OVERRIDE_BIT]) ? frsd_pkg::RM_ZERO
            : frsd_pkg::frsd_rmode_t'(fpStatusControl[frsd_pkg::RMODE_HI:
                                                      frsd_pkg::RMODE_LO]);
        destIndex_d = formIndex(dp, instr[frsd_pkg::DEST_HI:frsd_pkg::DEST_LO],
                                instr[frsd_pkg::DEST_EXT_BIT]);
        src1Index_d = formIndex(dp, instr[frsd_pkg::SRC1_HI:frsd_pkg::SRC1_LO],
                                instr[frsd_pkg::SRC1_EXT_BIT]);
        src2Index_d = formIndex(dp, instr[frsd_pkg::SRC2_HI:frsd_pkg::SRC2_LO],
                                instr[frsd_pkg::SRC2_EXT_BIT]);
        // Only four codes exist; the inverse tests come from swapped operands.
        cond = {instr[frsd_pkg::COND_HI:frsd_pkg::COND_LO],
                ^instr[frsd_pkg::COND_HI:frsd_pkg::COND_LO], 1'b0};
        // Flags come from the program flags word, never the FP status.
        case (cond[3:1])
            3'h0: condHolds_d = programFlags[frsd_pkg::FLAG_Z];
            3'h3: condHolds_d = programFlags[frsd_pkg::FLAG_V];
            3'h5: condHolds_d = programFlags[frsd_pkg::FLAG_N]
                                == programFlags[frsd_pkg::FLAG_V];
            3'h6: condHolds_d = !programFlags[frsd_pkg::FLAG_Z]
                                && (programFlags[frsd_pkg::FLAG_N]
                                    == programFlags[frsd_pkg::FLAG_V]);
            default: condHolds_d = 1'b0;
        endcase
    end

    // All decode outputs register together so faults line up with fields.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            decodeValid_q <= 1'b0;
            opKind_q <= frsd_pkg::OP_NONE;
            double_q <= 1'b0;
            destIndex_q <= '0;
            src1Index_q <= '0;
            src2Index_q <= '0;
            undefined_q <= 1'b0;
            unpredictable_q <= 1'b0;
            fpDisabled_q <= 1'b0;
            execA_q <= 1'b0;
            condHolds_q <= 1'b0;
            rmode_q <= frsd_pkg::RM_NEAREST;
        end else begin
            decodeValid_q <= decodeValid_d;
            opKind_q <= opKind_d;
            double_q <= double_d;
            destIndex_q <= destIndex_d;
            src1Index_q <= src1Index_d;
            src2Index_q <= src2Index_d;
            undefined_q <= undefined_d;
            unpredictable_q <= unpredictable_d;
            fpDisabled_q <= fpDisabled_d;
            execA_q <= execA_d;
            condHolds_q <= condHolds_d;
            rmode_q <= rmode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execute stage.

    frsd_round_if #(.W(frsd_pkg::SP_W)) spIf();
    frsd_round_if #(.W(frsd_pkg::DP_W)) dpIf();

    assign spIf.operand = src2Data[frsd_pkg::SP_W-1:0];
    assign spIf.rmode = rmode_q;
    assign dpIf.operand = src2Data;
    assign dpIf.rmode = rmode_q;

    frsd_round_int #(.EXP_W(frsd_pkg::SP_EXP_W), .MAN_W(frsd_pkg::SP_MAN_W))
        spRound (.port(spIf.unit));
    frsd_round_int #(.EXP_W(frsd_pkg::DP_EXP_W), .MAN_W(frsd_pkg::DP_MAN_W))
        dpRound (.port(dpIf.unit));

    logic isRound;
    logic rndInexact;
    logic rndInvalid;
    logic [63:0] resultData_d;
    logic inexact_d;
    logic invalid_d;

    always_comb begin
        isRound = opKind_q != frsd_pkg::OP_SELECT;
        rndInexact = double_q ? dpIf.inexact : spIf.inexact;
        rndInvalid = double_q ? dpIf.invalid : spIf.invalid;
        resultData_d = resultData_q;
        if (execA_q) begin
            if (!isRound) begin
                resultData_d = condHolds_q ? src1Data : src2Data;
            end else begin
                resultData_d = double_q ? dpIf.result
                                        : {32'h0, spIf.result};
            end
            if (!double_q) begin
                resultData_d[frsd_pkg::DP_W-1:frsd_pkg::SP_W] = 32'h0;
            end
        end
        inexact_d = execA_q && (opKind_q == frsd_pkg::OP_RINT_EXACT)
                    && rndInexact;
        invalid_d = execA_q && isRound && rndInvalid;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resultValid_q <= 1'b0;
            resultKind_q <= frsd_pkg::OP_NONE;
            resultDouble_q <= 1'b0;
            resultDest_q <= '0;
            resultData_q <= '0;
            inexact_q <= 1'b0;
            invalid_q <= 1'b0;
        end else begin
            resultValid_q <= execA_q;
            resultKind_q <= opKind_q;
            resultDouble_q <= double_q;
            resultDest_q <= destIndex_q;
            resultData_q <= resultData_d;
            inexact_q <= inexact_d;
            invalid_q <= invalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks. The past copies below feed only the assertions.

    logic [31:0] pastInstr_q;
    logic [31:0] pastFpsc_q;
    logic [3:0] pastFlags_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pastInstr_q <= '0;
            pastFpsc_q <= '0;
            pastFlags_q <= '0;
        end else begin
            pastInstr_q <= instr;
            pastFpsc_q <= fpStatusControl;
            pastFlags_q <= programFlags;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence legalIssueS;
        inGroup && fpExtPresent && !(dp && spOnlyImpl) && passes
            && fpAccessEnabled;
    endsequence

    sequence decodeThenResultS;
        decodeValid_q && !undefined_q ##1 resultValid_q;
    endsequence

    issue_to_result_a: assert property (legalIssueS |=> decodeThenResultS)
        else $error("legal instruction did not produce a result");
    enable_check_a: assert property (inGroup && !undefined_d && passes
            && !fpAccessEnabled |=> fpDisabled_q ##1 !resultValid_q)
        else $error("disabled FP access was not faulted");
    undef_nofp_a: assert property (inGroup && !fpExtPresent |=> undefined_q
            && decodeValid_q ##1 !resultValid_q)
        else $error("missing FP extension not flagged undefined");
    undef_sp_a: assert property (inGroup && dp && spOnlyImpl
            |=> undefined_q && double_q)
        else $error("double form not undefined on single-only");
    unpred_it_a: assert property (inGroup && isSel && inItBlock
            |=> unpredictable_q && decodeValid_q)
        else $error("select in if-then block not flagged");
    zero_rmode_a: assert property (inGroup && isRint
            && instr[frsd_pkg::OVERRIDE_BIT] |=> rmode_q == frsd_pkg::RM_ZERO)
        else $error("override bit did not force toward zero");
    exact_rmode_a: assert property (decodeValid_q
            && opKind_q == frsd_pkg::OP_RINT_EXACT |-> rmode_q
            == pastFpsc_q[frsd_pkg::RMODE_HI:frsd_pkg::RMODE_LO])
        else $error("exact form used wrong rounding mode");
    exact_decode_a: assert property (inGroup && isExact
            |=> opKind_q == frsd_pkg::OP_RINT_EXACT)
        else $error("exact form not recognised");
    no_inexact_a: assert property (resultValid_q
            && resultKind_q != frsd_pkg::OP_RINT_EXACT |-> !inexact_q)
        else $error("inexact raised by a non-exact form");
    cur_mode_a: assert property (inGroup && isRint
            && !instr[frsd_pkg::OVERRIDE_BIT] |=> rmode_q
            == pastFpsc_q[frsd_pkg::RMODE_HI:frsd_pkg::RMODE_LO])
        else $error("current-mode form used wrong mode");
    sp_index_a: assert property (decodeValid_q && !double_q |-> destIndex_q
            == {pastInstr_q[frsd_pkg::DEST_HI:frsd_pkg::DEST_LO],
                pastInstr_q[frsd_pkg::DEST_EXT_BIT]})
        else $error("single destination index misformed");
    src1_index_a: assert property (decodeValid_q && double_q |-> src1Index_q
            == {pastInstr_q[frsd_pkg::SRC1_EXT_BIT],
                pastInstr_q[frsd_pkg::SRC1_HI:frsd_pkg::SRC1_LO]})
        else $error("double first source index misformed");
    gt_cond_a: assert property (decodeValid_q && opKind_q == frsd_pkg::OP_SELECT
            && pastInstr_q[frsd_pkg::COND_HI:frsd_pkg::COND_LO] == 2'h3
            |-> condHolds_q == (!pastFlags_q[frsd_pkg::FLAG_Z]
            && pastFlags_q[frsd_pkg::FLAG_N] == pastFlags_q[frsd_pkg::FLAG_V]))
        else $error("greater-than condition wrong");
    select_pick_a: assert property (resultValid_q
            && resultKind_q == frsd_pkg::OP_SELECT && resultDouble_q
            |-> resultData_q == ($past(condHolds_q) ? $past(src1Data)
                                                   : $past(src2Data)))
        else $error("select wrote the wrong source");
    size_keep_a: assert property (resultValid_q && !resultDouble_q
            |-> resultData_q[frsd_pkg::DP_W-1:frsd_pkg::SP_W] == 32'h0)
        else $error("single result exceeded its size");
    precision_a: assert property (decodeValid_q
            |-> double_q == pastInstr_q[frsd_pkg::PRECISION_BIT])
        else $error("precision bit decoded wrongly");
endmodule

`default_nettype wire

// file: test/frsd_regfile_model.sv
/*
 * Register file model that sits on the far side of the FP round and select
 * decoder. It assumes the indices come from the decoder's stage-one
 * registers and answers them in the same cycle.
 */
`default_nettype none

module frsd_regfile_model (
    input wire logic clk,
    input wire logic readEn,
    input wire logic dbl,
    input wire logic [4:0] idx1,
    input wire logic [4:0] idx2,
    output logic [63:0] data1,
    output logic [63:0] data2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] junk = 64'h0;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [63:0] rd(logic d, logic [4:0] i);
        if (d) begin
            return (i == 5'h2) ? 64'h4004000000000000 : 64'h3ff8000000000000;
        end
        case (i)
            5'h1: return 64'h3fc00000;
            5'h2: return 64'h40200000;
            5'h3: return 64'h80000000;
            5'h4: return 64'h7f800000;
            5'h5: return 64'h40400000;
            5'h6: return 64'hc0200000;
            5'h7: return 64'h7fa00000;
            5'h8: return 64'h3f400000;
            default: return 64'h3f800000;
        endcase
    endfunction

    // Outside the answer cycle the lines toggle, so stale data never passes.
    always @(posedge clk) begin
        junk <= ~junk;
    end
    assign data1 = readEn ? rd(dbl, idx1) : junk;
    assign data2 = readEn ? rd(dbl, idx2) : junk;
endmodule

`default_nettype wire

// file: test/fp_round_select_decode_tb_top.sv
/*
 * Self-checking bench for the FP round and select decoder.
 * It assumes that the register file model answers one cycle after decode.
 */
`default_nettype none

module fp_round_select_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] EXA = 32'heeb70a40;
    localparam logic [31:0] ZER = 32'heeb60ac0;
    localparam logic [31:0] CUR = 32'heeb60a40;
    localparam logic [31:0] SEL = 32'hfe000a00;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic instrValid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] status = 32'h0;
    logic [31:0] sw;
    logic [3:0] flags = 4'h0;
    logic [3:0] fl;
    logic extOk = 1'b1;
    logic spOnly = 1'b0;
    logic fpOn = 1'b1;
    logic condOk = 1'b1;
    logic inIt = 1'b0;
    logic [63:0] d1, d2, resData, exp64;
    logic [4:0] dIdx, s1Idx, s2Idx, resDest;
    logic decValid, dbl, undef, unpred, fpDis, resValid, inexact, hold;
    logic inval, rDbl;
    frsd_pkg::frsd_op_t opKind, rKind;
    int mismatches = 0;
    int cmpCount = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    fp_round_select_decode i_dut (
        .clk(clk), .reset_n(reset_n), .instrValid(instrValid),
        .instr(instr), .instrCondPassed(condOk), .inItBlock(inIt),
        .fpExtPresent(extOk), .spOnlyImpl(spOnly), .fpAccessEnabled(fpOn),
        .fpStatusControl(status), .programFlags(flags), .src1Data(d1),
        .src2Data(d2), .decodeValid_q(decValid), .opKind_q(opKind),
        .double_q(dbl), .destIndex_q(dIdx), .src1Index_q(s1Idx),
        .src2Index_q(s2Idx), .undefined_q(undef), .unpredictable_q(unpred),
        .fpDisabled_q(fpDis), .resultValid_q(resValid),
        .resultKind_q(rKind), .resultDouble_q(rDbl),
        .resultDest_q(resDest), .resultData_q(resData),
        .inexact_q(inexact), .invalid_q(inval)
    );

    frsd_regfile_model i_regs (
        .clk(clk), .readEn(decValid), .dbl(dbl), .idx1(s1Idx),
        .idx2(s2Idx), .data1(d1), .data2(d2)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        cmpCount++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic setup(logic [1:0] mode, logic [3:0] f, logic [4:0] env);
        @(posedge clk);
        status <= {~f, 4'h0, mode, 22'h0};
        flags <= f;
        {extOk, spOnly, fpOn, condOk, inIt} <= env;
    endtask

    // Single forms use S7 and S9, double forms D17, as destination and src1.
    task automatic run(logic [31:0] b, logic dp, logic [4:0] m,
            logic [2:0] kind, logic [3:0] f, logic [63:0] data, logic inx);
        logic [4:0] d;
        logic [31:0] w;
        d = dp ? 5'h11 : 5'h7;
        w = b;
        w[8] = dp;
        w[22] = dp ? d[4] : d[0];
        w[15:12] = dp ? d[3:0] : d[4:1];
        w[5] = dp ? m[4] : m[0];
        w[3:0] = dp ? m[3:0] : m[4:1];
        if (b[28]) begin
            w[7] = dp ? 1'h1 : 1'h1;
            w[19:16] = dp ? 4'h1 : 4'h4;
        end
        @(posedge clk);
        instrValid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        chk("decodeValid", 64'h1, 64'(decValid));
        chk("flags", 64'(f[3:1]), 64'({undef, unpred, fpDis}));
        if (!f[3]) begin
            chk("opKind", 64'(kind), 64'(opKind));
            chk("destIndex", 64'(d), 64'(dIdx));
        end
        if (b[28]) begin
            chk("src1Index", 64'(dp ? 5'h11 : 5'h9), 64'(s1Idx));
        end
        @(posedge clk);
        #1;
        chk("resultValid", 64'(f[0]), 64'(resValid));
        if (f[0]) begin
            chk("resultData", data, resData);
            chk("result", 64'({d, inx}), 64'({resDest, inexact}));
            chk("resultKind", 64'({kind, dp}), 64'({rKind, rDbl}));
            chk("invalid", 64'(data == 64'h7fe00000), 64'(inval));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        setup(2'h0, 4'h0, 5'h16);
        run(EXA, 1'h0, 5'h2, 3'h2, 4'h1, 64'h40000000, 1'h1);
        run(EXA, 1'h0, 5'h5, 3'h2, 4'h1, 64'h40400000, 1'h0);
        run(EXA, 1'h0, 5'h3, 3'h2, 4'h1, 64'h80000000, 1'h0);
        run(EXA, 1'h0, 5'h4, 3'h2, 4'h1, 64'h7f800000, 1'h0);
        run(EXA, 1'h0, 5'h7, 3'h2, 4'h1, 64'h7fe00000, 1'h0);
        run(EXA, 1'h0, 5'h8, 3'h2, 4'h1, 64'h3f800000, 1'h1);
        run(EXA, 1'h1, 5'h2, 3'h2, 4'h1, 64'h4000000000000000, 1'h1);
        run(ZER, 1'h0, 5'h6, 3'h3, 4'h1, 64'hc0000000, 1'h0);
        setup(2'h1, 4'h0, 5'h16);
        run(CUR, 1'h0, 5'h1, 3'h1, 4'h1, 64'h40000000, 1'h0);
        run(ZER, 1'h0, 5'h1, 3'h3, 4'h1, 64'h3f800000, 1'h0);
        run(EXA, 1'h0, 5'h1, 3'h2, 4'h1, 64'h40000000, 1'h1);
        setup(2'h2, 4'h0, 5'h16);
        run(EXA, 1'h0, 5'h1, 3'h2, 4'h1, 64'h3f800000, 1'h1);
        setup(2'h3, 4'h0, 5'h16);
        run(EXA, 1'h0, 5'h1, 3'h2, 4'h1, 64'h3f800000, 1'h1);
        for (int cc = 0; cc < 4; cc++) begin
            for (int k = 0; k < 4; k++) begin
                fl = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'h4 : 4'h9;
                case (cc)
                    0: hold = fl[2];
                    1: hold = fl[0];
                    2: hold = (fl[3] == fl[0]);
                    default: hold = !fl[2] && (fl[3] == fl[0]);
                endcase
                exp64 = hold ? 64'h3f800000 : 64'h40200000;
                sw = SEL;
                sw[21:20] = cc[1:0];
                setup(2'h0, fl, 5'h16);
                run(sw, 1'h0, 5'h2, 3'h4, 4'h1, exp64, 1'h0);
            end
        end
        setup(2'h0, 4'h4, 5'h16);
        run(SEL, 1'h1, 5'h2, 3'h4, 4'h1, 64'h3ff8000000000000, 1'h0);
        setup(2'h0, 4'h0, 5'h06);
        run(EXA, 1'h0, 5'h2, 3'h2, 4'h8, 64'h0, 1'h0);
        setup(2'h0, 4'h0, 5'h1e);
        run(EXA, 1'h1, 5'h2, 3'h2, 4'h8, 64'h0, 1'h0);
        run(SEL, 1'h1, 5'h2, 3'h4, 4'h8, 64'h0, 1'h0);
        run(EXA, 1'h0, 5'h2, 3'h2, 4'h1, 64'h40000000, 1'h1);
        setup(2'h0, 4'h0, 5'h12);
        run(EXA, 1'h0, 5'h2, 3'h2, 4'h2, 64'h0, 1'h0);
        setup(2'h0, 4'h0, 5'h14);
        run(EXA, 1'h0, 5'h2, 3'h2, 4'h0, 64'h0, 1'h0);
        setup(2'h0, 4'h4, 5'h17);
        run(SEL, 1'h0, 5'h2, 3'h4, 4'h5, 64'h3f800000, 1'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
